// >>> sim/pmf_framer_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pmf_framer_bench
  import pmf_pkg::*;
;
  typedef pmf_byte_t pmf_bytes_t[$];
  logic       clock_in, rst_b_in, tx_wr_en, tx_req, irq_ack, irq;
  logic       tx_busy, rx_crc_ok, link_clk, rx_bit, tx_bit, tx_en;
  pmf_addr_t  tx_wr_addr, rx_rd_addr;
  pmf_word_t  tx_wr_data, rx_rd_data;
  logic [6:0] tx_len, rx_len;
  pmf_byte_t  lqi_level;
  int         num_errors, checks, cycles;

  pmf_framer i_dut (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .tx_wr_en_in(tx_wr_en),
    .tx_wr_addr_in(tx_wr_addr), .tx_wr_data_in(tx_wr_data),
    .tx_req_in(tx_req), .tx_len_in(tx_len), .rx_rd_addr_in(rx_rd_addr),
    .rx_rd_data_out(rx_rd_data), .irq_ack_in(irq_ack), .irq_out(irq),
    .tx_busy_out(tx_busy), .rx_crc_ok_out(rx_crc_ok), .rx_len_out(rx_len),
    .link_clk_in(link_clk), .rx_bit_in(rx_bit),
    .lqi_level_in(lqi_level), .tx_bit_out(tx_bit), .tx_en_out(tx_en));

  pmf_link_model i_link (
    .tx_bit_in(tx_bit), .tx_en_in(tx_en), .link_clk_out(link_clk),
    .rx_bit_out(rx_bit), .lqi_level_out(lqi_level));

  always #25 clock_in = ~clock_in;

  // Hang guard, well above the whole sequence
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : check

  // Reflected CRC, bit by bit, so no table is shared with the design
  function automatic pmf_word_t crc_of(input pmf_bytes_t p);
    pmf_word_t c = 16'h0000;
    foreach (p[i])
    begin
      c = c ^ {8'h00, p[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return c;
  endfunction : crc_of

  function automatic pmf_bytes_t make_pay(input int len);
    pmf_bytes_t p;
    for (int k = 0; k < len; k++)
      p.push_back(8'(k * 29 + len + 1));
    return p;
  endfunction : make_pay

  // Preamble, delimiter, length, payload, check bytes low first
  function automatic pmf_bytes_t make_frame(input pmf_bytes_t p,
                                            input bit         bad);
    pmf_word_t c = crc_of(p) ^ {15'h0000, bad};
    pmf_bytes_t f = {8'h00, 8'h00, 8'h00, 8'h00, 8'hA7, 8'(p.size() + 2)};
    return {f, p, c[7:0], c[15:8]};
  endfunction : make_frame

  task automatic wait_irq(input int lim);
    for (int n = 0; n < lim && irq !== 1'b1; n++)
      @(negedge clock_in);
    check("irq set", 16'h0001, irq);
    @(negedge clock_in);
    irq_ack = 1'b1;
    @(negedge clock_in);
    irq_ack = 1'b0;
    check("irq clear", 16'h0000, irq);
  endtask : wait_irq

  task automatic test_tx(input int len);
    pmf_bytes_t pay = make_pay(len);
    pmf_bytes_t fr = make_frame(pay, 1'b0);
    for (int w = 0; 2 * w < len; w++)
    begin
      @(negedge clock_in);
      tx_wr_en = 1'b1;
      tx_wr_addr = 6'(w);
      tx_wr_data = {(2 * w + 1 < len) ? pay[2 * w + 1] : 8'h00, pay[2 * w]};
    end
    @(negedge clock_in);
    tx_wr_en = 1'b0; // Whole payload loaded before the request
    tx_req = 1'b1;
    tx_len = 7'(len);
    i_link.seen.delete();
    @(negedge clock_in);
    tx_req = 1'b0;
    check("tx busy", 16'h0001, tx_busy);
    // Host write and a second request while busy must both be ignored;
    // a landed write would corrupt payload word 0 in the bit compare
    @(negedge clock_in);
    tx_wr_en = 1'b1;
    tx_wr_addr = 6'h00;
    tx_wr_data = 16'hFFFF;
    tx_req = 1'b1;
    @(negedge clock_in);
    tx_wr_en = 1'b0;
    tx_req = 1'b0;
    check("busy kept", 16'h0001, tx_busy);
    i_link.run = 1'b1;
    wait_irq(20000);
    i_link.run = 1'b0;
    check("bits", 16'(fr.size() * 8), 16'(i_link.seen.size()));
    for (int i = 0; i < fr.size() * 8; i++)
      check("tx bit", 16'(fr[i / 8][i % 8]), 16'(i_link.seen[i]));
    check("tx idle", 16'h0000, tx_busy);
  endtask : test_tx

  task automatic test_refuse();
    @(negedge clock_in);
    tx_req = 1'b1;
    tx_len = 7'h7E;
    @(negedge clock_in);
    tx_req = 1'b0;
    @(negedge clock_in);
    check("refused", 16'h0000, tx_busy);
  endtask : test_refuse

  task automatic test_rx(input int len, input bit bad);
    pmf_bytes_t fr = make_frame(make_pay(len), bad);
    pmf_word_t w;
    i_link.lqi_level_out = 8'h5A;
    i_link.run = 1'b1;
    fork
      i_link.send_frame(fr);
      begin
        repeat (1800) @(negedge clock_in);
        i_link.lqi_level_out = 8'hF0; // Past the quality window
      end
    join
    i_link.run = 1'b0;
    check("rx len", 16'(len + 2), rx_len);
    check("crc ok", 16'(!bad), rx_crc_ok);
    for (int k = 0; k < len + 2; k += 2)
    begin
      @(negedge clock_in);
      rx_rd_addr = 6'(k / 2);
      @(negedge clock_in);
      w = rx_rd_data;
      check("rx low", fr[6 + k], w[7:0]);
      if (k + 1 < len + 2) check("rx high", fr[7 + k], w[15:8]);
    end
    @(negedge clock_in);
    rx_rd_addr = 6'h3F;
    @(negedge clock_in);
    check("lqi", 16'h005A, rx_rd_data[15:8]);
    wait_irq(100);
  endtask : test_rx

  task automatic test_bad_len();
    pmf_bytes_t fr = make_frame(make_pay(4), 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      fr[5] = j ? 8'h80 : 8'h01;
      i_link.run = 1'b1;
      i_link.send_frame(fr);
      repeat (100) @(negedge clock_in);
      i_link.run = 1'b0;
      check("no irq", 16'h0000, irq);
    end
  endtask : test_bad_len

  initial
  begin
    {clock_in, rst_b_in, tx_wr_en, tx_req, irq_ack} = 5'h00;
    tx_wr_addr = 6'h00;
    rx_rd_addr = 6'h00;
    tx_wr_data = 16'h0000;
    tx_len = 7'h00;
    repeat (5) @(negedge clock_in);
    rst_b_in = 1'b1;
    test_tx(3);
    test_tx(125);
    test_refuse();
    test_rx(40, 1'b0);
    test_rx(5, 1'b1);
    test_bad_len();
    report_and_stop();
  end
endmodule : pmf_framer_bench
`default_nettype wire

// >>> sim/pmf_framer_props.sv
`timescale 1ns/1ps
`default_nettype none

// Port watcher for the framer; one clock domain
module pmf_framer_props
  import pmf_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       rst_b_in,
  input wire logic       tx_req_in,
  input wire logic [6:0] tx_len_in,
  input wire logic       irq_ack_in,
  input wire logic       irq_out,
  input wire logic       tx_busy_out,
  input wire logic       rx_crc_ok_out,
  input wire logic [6:0] rx_len_out,
  input wire logic       tx_bit_out,
  input wire logic       tx_en_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  // Steps of a request, a bit slot and a receive result
  sequence take_req;
    tx_req_in && !tx_busy_out && tx_len_in <= 7'h7D;
  endsequence
  sequence bad_req;
    tx_req_in && !tx_busy_out && tx_len_in > 7'h7D;
  endsequence
  sequence bit_slot;
    $stable(tx_bit_out)[*6];
  endsequence
  sequence rx_result;
    $changed(rx_len_out) || $changed(rx_crc_ok_out);
  endsequence

  chk_req_starts_tx: assert property (take_req |=> tx_busy_out)
    else $error("transmit request not taken");
  chk_long_refused: assert property (bad_req |=> !tx_busy_out)
    else $error("overlong request taken");
  chk_en_in_busy: assert property (tx_en_out |-> tx_busy_out)
    else $error("frame bits outside busy");
  chk_busy_ends_irq: assert property
    ($fell(tx_busy_out) |-> irq_out && $past(tx_en_out))
    else $error("transmit end without interrupt");
  chk_no_irq_mid: assert property (tx_busy_out |-> !$rose(irq_out))
    else $error("interrupt during transmit");
  chk_bit_holds: assert property
    (tx_en_out && $changed(tx_bit_out) |=> bit_slot)
    else $error("bit shorter than a link slot");
  chk_irq_sticky: assert property (irq_out && !irq_ack_in |=> irq_out)
    else $error("interrupt dropped without ack");
  chk_irq_clear_ack: assert property
    ($fell(irq_out) |-> $past(irq_ack_in))
    else $error("interrupt cleared without ack");
  chk_rx_with_irq: assert property (rx_result |-> $rose(irq_out))
    else $error("receive result without interrupt");
  chk_rx_len_bound: assert property
    ($changed(rx_len_out) |-> rx_len_out >= 7'h02)
    else $error("stored length below two");
endmodule : pmf_framer_props

bind pmf_framer pmf_framer_props i_props (
  .clock_in, .rst_b_in, .tx_req_in, .tx_len_in, .irq_ack_in, .irq_out,
  .tx_busy_out, .rx_crc_ok_out, .rx_len_out, .tx_bit_out, .tx_en_out
);
`default_nettype wire

// >>> sim/pmf_link_model.sv
`timescale 1ns/1ps
`default_nettype none

// Modulator and demodulator side of the bit link
module pmf_link_model
  import pmf_pkg::*;
(
  input  wire logic tx_bit_in,
  input  wire logic tx_en_in,
  output logic      link_clk_out,
  output logic      rx_bit_out,
  output pmf_byte_t lqi_level_out
);
  logic run;
  logic seen[$];

  initial
  begin
    run = 1'b0;
    link_clk_out = 1'b0;
    rx_bit_out = 1'b1;
    lqi_level_out = 8'h00;
  end

  // Clock stands low between frames
  always #200 link_clk_out = run ? ~link_clk_out : 1'b0;

  // Sample mid-slot, well after the sender updates
  always @(negedge link_clk_out)
    if (tx_en_in)
      seen.push_back(tx_bit_in);

  // Bits LSB first, changed on the falling edge
  task automatic send_frame(input pmf_byte_t fr[$]);
    foreach (fr[i])
      for (int b = 0; b < 8; b++)
      begin
        @(negedge link_clk_out);
        rx_bit_out = fr[i][b];
      end
    @(negedge link_clk_out);
    rx_bit_out = ~rx_bit_out; // Released line shows no stale bit
  endtask : send_frame
endmodule : pmf_link_model
`default_nettype wire

// >>> src/pmf_cfg.svh
// Function
// - Separate transmit and receive buffers, each 64 words of 16 bits.
// - Payloads of any length up to 125 bytes, both directions.
// - Transmit prepends four zero preamble bytes, start delimiter, length byte.
// - Two-byte check sequence over payload appended after last payload byte.
// - Receiver finds preamble, delimiter, length; stores payload and check bytes.
// - Receiver recomputes check sequence, compares, reports pass or fail.
// - Link quality measured for 64 us after preamble, stored in buffer.
// - Receive handled as whole frames; interrupt once a frame is stored.
// - On request, read transmit buffer, build frame, send it to the modulator.
// - Interrupt raised only after the whole transmit frame has gone out.
`ifndef PMF_CFG_SVH
`define PMF_CFG_SVH

`define PMF_CLK_MHZ     20
`define PMF_LQI_NS      64000
`define PMF_LQI_CYC     11'((`PMF_LQI_NS * `PMF_CLK_MHZ + 999) / 1000)
`define PMF_WORDS       64
`define PMF_PRE_BYTES   8'h04
`define PMF_SFD         8'hA7
`define PMF_MAX_PAY     7'h7D
`define PMF_FCS_LEN     7'h02
`define PMF_MIN_FLI     7'h02
`define PMF_MAX_FLI     7'h7F
`define PMF_HDR_BYTES   8'h06
`define PMF_CRC_POLY    16'h8408
`define PMF_CRC_INIT    16'h0000
`define PMF_LQI_WORD    6'h3F
`define PMF_LQI_LANE    2'h2

`endif

// >>> src/pmf_crc.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmf_cfg.svh"

// Bit-serial reflected CRC-16, one bit per enable
module pmf_crc
  import pmf_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  input  wire logic clear_in,
  input  wire logic en_in,
  input  wire logic bit_in,
  output pmf_word_t crc_out
);
  pmf_word_t crc_ff;
  wire       fb = crc_ff[0] ^ bit_in;
  wire pmf_word_t nxt_crc =
    (crc_ff >> 1) ^ (fb ? `PMF_CRC_POLY : 16'h0000);

  assign crc_out = crc_ff;

  // Clear has priority; start value zero
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in || clear_in)
      crc_ff <= `PMF_CRC_INIT;
    else if (en_in)
      crc_ff <= nxt_crc;
  end
endmodule : pmf_crc
`default_nettype wire

// >>> src/pmf_framer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmf_cfg.svh"

// Packet-mode buffer and framer; bits travel LSB first on the link
module pmf_framer
  import pmf_pkg::*;
(
  input  wire logic      clock_in,
  input  wire logic      rst_b_in,
  // Host side
  input  wire logic      tx_wr_en_in,
  input  wire pmf_addr_t tx_wr_addr_in,
  input  wire pmf_word_t tx_wr_data_in,
  input  wire logic      tx_req_in,
  input  wire logic [6:0] tx_len_in,
  input  wire pmf_addr_t rx_rd_addr_in,
  output pmf_word_t      rx_rd_data_out,
  input  wire logic      irq_ack_in,
  output logic           irq_out,
  output logic           tx_busy_out,
  output logic           rx_crc_ok_out,
  output logic [6:0]     rx_len_out,
  // Link side
  input  wire logic      link_clk_in,
  input  wire logic      rx_bit_in,
  input  wire pmf_byte_t lqi_level_in,
  output logic           tx_bit_out,
  output logic           tx_en_out
);
  // Synchronisers for pins from the link domain
  logic      lclk_s1_ff, lclk_s2_ff, lclk_s3_ff;
  logic      rxb_s1_ff, rxb_s2_ff;
  pmf_byte_t lqi_s1_ff, lqi_s2_ff;

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      {lclk_s1_ff, lclk_s2_ff, lclk_s3_ff} <= 3'h0;
      {rxb_s1_ff, rxb_s2_ff}               <= 2'h0;
      lqi_s1_ff                            <= 8'h00;
      lqi_s2_ff                            <= 8'h00;
    end
    else
    begin
      lclk_s1_ff <= link_clk_in;
      lclk_s2_ff <= lclk_s1_ff;
      lclk_s3_ff <= lclk_s2_ff;
      rxb_s1_ff  <= rx_bit_in;
      rxb_s2_ff  <= rxb_s1_ff;
      lqi_s1_ff  <= lqi_level_in;
      lqi_s2_ff  <= lqi_s1_ff;
    end
  end

  // One bit slot per rising link edge
  wire link_rise = lclk_s2_ff && !lclk_s3_ff;

  // Transmit state
  pmf_tx_e    tx_st_ff;
  logic [7:0] tx_idx_ff;
  logic [2:0] tx_bitc_ff;
  pmf_byte_t  tx_sh_ff;
  logic [6:0] tx_len_ff;
  logic       tx_pay_ff;
  logic       tx_bit_ff, tx_en_ff;
  pmf_word_t  tx_rd_data, tx_crc;

  // Receive state
  pmf_rx_e    rx_st_ff;
  logic [39:0] rx_sr_ff;
  logic [2:0] rx_bitc_ff;
  logic [6:0] rx_cnt_ff, rx_fli_ff;
  pmf_word_t  rx_fcs_ff, rx_crc;
  pmf_byte_t  lqi_ff;
  logic [10:0] lqi_win_ff;
  logic       rx_crc_ok_ff;
  logic [6:0] rx_len_ff;
  logic       irq_ff;

  // Transmit byte sequencing
  wire [7:0] pay_end  = {1'b0, tx_len_ff} + `PMF_HDR_BYTES;
  wire [7:0] tx_total = pay_end + {1'b0, `PMF_FCS_LEN};
  wire [7:0] pay_idx  = tx_idx_ff - `PMF_HDR_BYTES;
  wire       idx_pay  = (tx_idx_ff >= `PMF_HDR_BYTES) &&
                        (tx_idx_ff < pay_end);
  wire pmf_byte_t pay_byte = pay_idx[0] ? tx_rd_data[15:8]
                                        : tx_rd_data[7:0];
  wire pmf_byte_t fli_byte = {1'b0, tx_len_ff + `PMF_FCS_LEN};
  wire pmf_byte_t tx_byte =
    (tx_idx_ff < `PMF_PRE_BYTES)        ? 8'h00 :
    (tx_idx_ff == `PMF_PRE_BYTES)       ? `PMF_SFD :
    (tx_idx_ff == `PMF_HDR_BYTES - 8'h01) ? fli_byte :
    idx_pay                             ? pay_byte :
    (tx_idx_ff == pay_end)              ? tx_crc[7:0]
                                        : tx_crc[15:8];

  wire tx_start = tx_req_in && (tx_st_ff == TX_IDLE) &&
                  (tx_len_in <= `PMF_MAX_PAY);
  wire tx_step  = (tx_st_ff == TX_RUN) && link_rise;
  wire tx_load  = tx_step && (tx_bitc_ff == 3'h0);
  wire tx_end   = tx_load && (tx_idx_ff == tx_total);
  wire nxt_tx_bit = tx_load ? tx_byte[0] : tx_sh_ff[0];
  wire tx_crc_en  = tx_step && !tx_end &&
                    (tx_load ? idx_pay : tx_pay_ff);

  // Transmit sequencer; the frame ends one bit slot after its last bit
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      tx_st_ff   <= TX_IDLE;
      tx_idx_ff  <= 8'h00;
      tx_bitc_ff <= 3'h0;
      tx_sh_ff   <= 8'h00;
      tx_len_ff  <= 7'h00;
      tx_pay_ff  <= 1'b0;
      tx_bit_ff  <= 1'b0;
      tx_en_ff   <= 1'b0;
    end
    else if (tx_start)
    begin
      tx_st_ff   <= TX_RUN;
      tx_len_ff  <= tx_len_in;
      tx_idx_ff  <= 8'h00;
      tx_bitc_ff <= 3'h0;
    end
    else if (tx_end)
    begin
      tx_st_ff  <= TX_IDLE;
      tx_en_ff  <= 1'b0;
      tx_bit_ff <= 1'b0;
    end
    else if (tx_step)
    begin
      tx_bit_ff  <= nxt_tx_bit;
      tx_en_ff   <= 1'b1;
      tx_bitc_ff <= tx_bitc_ff + 3'h1;
      if (tx_load)
      begin
        tx_sh_ff  <= {1'b0, tx_byte[7:1]};
        tx_pay_ff <= idx_pay;
        tx_idx_ff <= tx_idx_ff + 8'h01;
      end
      else
        tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
    end
  end

  // Writes blocked while sending so the frame cannot change under us
  wire tx_host_wr = tx_wr_en_in && (tx_st_ff == TX_IDLE);

  pmf_ram u_tx_ram (
    .clock_in    (clock_in),
    .rst_b_in    (rst_b_in),
    .wr_en_in    (tx_host_wr),
    .wr_lane_in  (2'h3),
    .wr_addr_in  (tx_wr_addr_in),
    .wr_data_in  (tx_wr_data_in),
    .rd_addr_in  (pay_idx[6:1]),
    .rd_data_out (tx_rd_data)
  );

  pmf_crc u_tx_crc (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .clear_in (tx_start),
    .en_in    (tx_crc_en),
    .bit_in   (nxt_tx_bit),
    .crc_out  (tx_crc)
  );

  // Receive bit assembly: newest bit enters at the top
  wire        rx_step   = link_rise && (rx_st_ff != RX_DONE);
  wire [39:0] nxt_sr    = {rxb_s2_ff, rx_sr_ff[39:1]};
  wire        rx_byte_ok = rx_step && (rx_bitc_ff == 3'h7);
  wire pmf_byte_t rx_byte = nxt_sr[39:32];
  wire        sfd_hit   = rx_step && (rx_st_ff == RX_HUNT) &&
                          (nxt_sr == {`PMF_SFD, 32'h0});
  wire        fli_ok    = (rx_byte[6:0] >= `PMF_MIN_FLI) &&
                          !rx_byte[7];
  wire [6:0]  pay_cnt   = rx_fli_ff - `PMF_FCS_LEN;
  wire        rx_in_pay = (rx_st_ff == RX_DATA) && (rx_cnt_ff < pay_cnt);
  wire        rx_last   = rx_cnt_ff == rx_fli_ff - 7'h01;
  wire        rx_done   = rx_st_ff == RX_DONE;

  // Receive buffer port: data bytes, then link quality on completion
  wire        rx_wr      = (rx_byte_ok && rx_st_ff == RX_DATA) || rx_done;
  wire [1:0]  rx_lane    = rx_done ? `PMF_LQI_LANE
                                   : {rx_cnt_ff[0], !rx_cnt_ff[0]};
  wire pmf_addr_t rx_waddr = rx_done ? `PMF_LQI_WORD : rx_cnt_ff[6:1];
  wire pmf_byte_t rx_wbyte = rx_done ? lqi_ff : rx_byte;

  // Receive parser
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      rx_st_ff   <= RX_HUNT;
      rx_sr_ff   <= 40'h00_0000_0000;
      rx_bitc_ff <= 3'h0;
      rx_cnt_ff  <= 7'h00;
      rx_fli_ff  <= 7'h00;
      rx_fcs_ff  <= 16'h0000;
    end
    else
    begin
      unique case (rx_st_ff)
        RX_HUNT:
        begin
          if (rx_step)
            rx_sr_ff <= nxt_sr;
          if (sfd_hit)
          begin
            rx_st_ff   <= RX_LEN;
            rx_bitc_ff <= 3'h0;
          end
        end
        RX_LEN:
        begin
          if (rx_step)
          begin
            rx_sr_ff   <= nxt_sr;
            rx_bitc_ff <= rx_bitc_ff + 3'h1;
          end
          if (rx_byte_ok)
          begin
            rx_fli_ff <= rx_byte[6:0];
            rx_cnt_ff <= 7'h00;
            rx_st_ff  <= fli_ok ? RX_DATA : RX_HUNT;
          end
        end
        RX_DATA:
        begin
          if (rx_step)
          begin
            rx_sr_ff   <= nxt_sr;
            rx_bitc_ff <= rx_bitc_ff + 3'h1;
          end
          if (rx_byte_ok)
          begin
            if (!rx_in_pay)
              rx_fcs_ff <= {rx_byte, rx_fcs_ff[15:8]};
            rx_cnt_ff <= rx_cnt_ff + 7'h01;
            if (rx_last)
              rx_st_ff <= RX_DONE;
          end
        end
        RX_DONE:
        begin
          rx_st_ff <= RX_HUNT;
          rx_sr_ff <= 40'h00_0000_0000;
        end
      endcase
    end
  end

  pmf_ram u_rx_ram (
    .clock_in    (clock_in),
    .rst_b_in    (rst_b_in),
    .wr_en_in    (rx_wr),
    .wr_lane_in  (rx_lane),
    .wr_addr_in  (rx_waddr),
    .wr_data_in  ({rx_wbyte, rx_wbyte}),
    .rd_addr_in  (rx_rd_addr_in),
    .rd_data_out (rx_rd_data_out)
  );

  pmf_crc u_rx_crc (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .clear_in (sfd_hit),
    .en_in    (rx_step && rx_in_pay),
    .bit_in   (rxb_s2_ff),
    .crc_out  (rx_crc)
  );

  // Link quality: peak level over the window after the preamble;
  // peak avoids a divider for a non power-of-two window
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      lqi_ff     <= 8'h00;
      lqi_win_ff <= 11'h000;
    end
    else if (sfd_hit)
    begin
      lqi_ff     <= lqi_s2_ff;
      lqi_win_ff <= `PMF_LQI_CYC - 11'h001;
    end
    else if (lqi_win_ff != 11'h000)
    begin
      lqi_win_ff <= lqi_win_ff - 11'h001;
      if (lqi_s2_ff > lqi_ff)
        lqi_ff <= lqi_s2_ff;
    end
  end

  // Results and interrupt; a new event beats a same-cycle acknowledge
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      rx_crc_ok_ff <= 1'b0;
      rx_len_ff    <= 7'h00;
      irq_ff       <= 1'b0;
    end
    else
    begin
      if (rx_done)
      begin
        rx_crc_ok_ff <= rx_crc == rx_fcs_ff;
        rx_len_ff    <= rx_fli_ff;
      end
      if (rx_done || tx_end)
        irq_ff <= 1'b1;
      else if (irq_ack_in)
        irq_ff <= 1'b0;
    end
  end

  // Host-side and link-side outputs
  assign irq_out       = irq_ff;
  assign tx_busy_out   = tx_st_ff == TX_RUN ? 1'b1 : 1'b0;
  assign rx_crc_ok_out = rx_crc_ok_ff;
  assign rx_len_out    = rx_len_ff;
  assign tx_bit_out    = tx_bit_ff;
  assign tx_en_out     = tx_en_ff;
endmodule : pmf_framer
`default_nettype wire

// >>> src/pmf_pkg.sv
package pmf_pkg;
  typedef logic [7:0]  pmf_byte_t;
  typedef logic [15:0] pmf_word_t;
  typedef logic [5:0]  pmf_addr_t;

  typedef enum logic [0:0] {
    TX_IDLE,
    TX_RUN
  } pmf_tx_e;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_LEN,
    RX_DATA,
    RX_DONE
  } pmf_rx_e;
endpackage : pmf_pkg

// >>> src/pmf_ram.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmf_cfg.svh"

// Packet buffer: flip-flop words, byte-lane writes, registered read
module pmf_ram
  import pmf_pkg::*;
(
  input  wire logic      clock_in,
  input  wire logic      rst_b_in,
  input  wire logic      wr_en_in,
  input  wire logic [1:0] wr_lane_in,
  input  wire pmf_addr_t wr_addr_in,
  input  wire pmf_word_t wr_data_in,
  input  wire pmf_addr_t rd_addr_in,
  output pmf_word_t      rd_data_out
);
  pmf_word_t mem_ff [`PMF_WORDS];
  pmf_word_t rd_data_ff;

  assign rd_data_out = rd_data_ff;

  // One entry per word, lanes written independently
  genvar gi;
  generate
    for (gi = 0; gi < `PMF_WORDS; gi++)
    begin : g_word
      wire hit = wr_en_in && (wr_addr_in == 6'(gi));
      always_ff @(posedge clock_in)
      begin
        if (!rst_b_in)
          mem_ff[gi] <= 16'h0000;
        else if (hit)
        begin
          if (wr_lane_in[0]) mem_ff[gi][7:0]  <= wr_data_in[7:0];
          if (wr_lane_in[1]) mem_ff[gi][15:8] <= wr_data_in[15:8];
        end
      end
    end
  endgenerate

  // Registered read so the data port stays a clean flop output
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      rd_data_ff <= 16'h0000;
    else
      rd_data_ff <= mem_ff[rd_addr_in];
  end
endmodule : pmf_ram
`default_nettype wire
